//--- src/sdir_top.sv
// Purpose: Serial shift register and hold register of a 12-bit current converter
// Assumes: Strobes, loads and data are pins, sampled by clk; clear_n acts asynchronously
// Notes:   Idle-level gating is checked on the synchronised pin levels
`timescale 1ns/1ps
module sdir_top
   import sdir_pkg::*;
(
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst,
   // Strobe pins
   input  wire logic                  strobe_rise_a,
   input  wire logic                  strobe_rise_b,
   input  wire logic                  strobe_rise_c,
   input  wire logic                  strobe_fall,
   // Serial data pin
   input  wire logic                  serial_in,
   // Hold register control pins
   input  wire logic                  load_enable_a,
   input  wire logic                  load_enable_b,
   input  wire logic                  clear_n,
   // Converter side
   output logic      [SDIR_WIDTH-1:0] current_out_main,
   output logic      [SDIR_WIDTH-1:0] current_out_comp,
   output logic      [SDIR_WIDTH-1:0] shift_value,
   output logic      [SDIR_WIDTH-1:0] hold_value
);
   // Synchronised pins: {data, fall, c, b, a, load_b, load_a}
   logic [6:0]            pins_sync;          // Second stage outputs
   logic                  sra, srb, src, sfl; // Synced strobes
   logic                  sdat, lda, ldb;     // Synced data and loads
   logic [3:0]            strb_prev_reg;      // Previous strobe levels
   logic [SDIR_WIDTH-1:0] shift_reg;          // Serial-in shift register
   logic [SDIR_WIDTH-1:0] shift_next;         // Next shift value
   logic [SDIR_WIDTH-1:0] dac_hold_reg;       // Converter hold register
   logic [SDIR_WIDTH-1:0] dac_comp_reg;       // Inverted copy for the complement bus
   logic                  edge_a, edge_b, edge_c, edge_f; // Qualified edges
   logic                  do_shift;           // Any valid strobe edge
   logic                  do_load;            // Loads both low

   // Data, strobes and loads are foreign to clk, so two flops each
   sdir_sync #(.W(7)) u_sync (
      .clk       (clk),
      .rst       (rst),
      .pin_in    ({serial_in, strobe_fall, strobe_rise_c, strobe_rise_b,
                   strobe_rise_a, load_enable_b, load_enable_a}),
      .rst_value (7'h00),
      .sync_out  (pins_sync)
   );
   assign {sdat, sfl, src, srb, sra, ldb, lda} = pins_sync;

   // Previous strobe levels; reset to what the synchroniser shows in reset
   // The synchroniser resets low, so a high reset here for the fall strobe
   // would fake a falling edge at the first clock after release
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         strb_prev_reg <= '0;    // Matches synchronised levels in reset
      end else begin
         strb_prev_reg <= {sfl, src, srb, sra};
      end
   end

   // Each edge counts only while the other three sit idle
   assign edge_a = sra & ~strb_prev_reg[0] & ~srb & ~src & sfl;
   assign edge_b = srb & ~strb_prev_reg[1] & ~sra & ~src & sfl;
   assign edge_c = src & ~strb_prev_reg[2] & ~sra & ~srb & sfl;
   assign edge_f = ~sfl & strb_prev_reg[3] & ~sra & ~srb & ~src;
   assign do_shift = edge_a | edge_b | edge_c | edge_f;
   // MSB arrives first, so it ends at the top after twelve shifts
   assign shift_next = {shift_reg[SDIR_WIDTH-2:0], sdat};

   // Shift register: only system reset, never clear_n, resets it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         shift_reg <= SDIR_SHIFT_RST;
      end else if (do_shift) begin
         shift_reg <= shift_next;
      end
   end
   // No else branch: holds otherwise, including loads and clears

   // Load is a level: hold follows shift while both loads are low
   assign do_load = ~lda & ~ldb;

   // Hold register; clear_n acts asynchronously, unsynchronised on purpose
   // The complement bus has its own flops so both buses switch together
   // Limitation: clear released right at a clock edge risks recovery trouble
   always_ff @(posedge clk or posedge rst or negedge clear_n) begin
      if (rst) begin
         dac_hold_reg <= SDIR_CLEAR_CODE;
         dac_comp_reg <= ~SDIR_CLEAR_CODE;
      end else if (!clear_n) begin
         // Clear wins over any load level
         dac_hold_reg <= SDIR_CLEAR_CODE;
         dac_comp_reg <= ~SDIR_CLEAR_CODE;
      end else if (do_load) begin
         // Level load: hold tracks shift while both loads stay low
         dac_hold_reg <= shift_reg;
         dac_comp_reg <= ~shift_reg;
      end
   end
   // Either load high: register keeps its value

   // Switch steering: set bit to main bus, clear bit to complement bus
   assign current_out_main = dac_hold_reg;
   assign current_out_comp = dac_comp_reg;
   assign shift_value      = shift_reg;
   assign hold_value       = dac_hold_reg;

   // Assertions: system clock, all disabled while reset is high
   // Named sequences carry the antecedent parts of the checks below

   // Clear pin held low at a sample edge
   sequence s_clr_low;
      !clear_n;
   endsequence
   // Other three strobes at rest, one sequence per rising strobe
   sequence s_idle_but_a;
      !srb && !src && sfl;
   endsequence
   sequence s_idle_but_b;
      !sra && !src && sfl;
   endsequence
   sequence s_idle_but_c;
      !sra && !srb && sfl;
   endsequence
   // All three rising strobes at rest, for the fall strobe
   sequence s_idle_but_fall;
      !sra && !srb && !src;
   endsequence
   // Both loads low, and clear still released at the next edge
   sequence s_load_window;
      (clear_n && do_load) ##1 clear_n;
   endsequence
   // A load high, and clear still released at the next edge
   sequence s_hold_window;
      (!do_load && clear_n) ##1 clear_n;
   endsequence

   // Clear forces both buses at once and spares the shift register
   a_clear_zero_hold: assert property (@(posedge clk) disable iff (rst)
      s_clr_low |-> dac_hold_reg == SDIR_CLEAR_CODE)
      else $error("hold not zero under clear");
   a_clear_zero_comp: assert property (@(posedge clk) disable iff (rst)
      s_clr_low |-> current_out_comp == ~SDIR_CLEAR_CODE)
      else $error("complement bus not full under clear");
   a_clear_keep_shift: assert property (@(posedge clk) disable iff (rst)
      (!clear_n && !do_shift) |=> shift_reg == $past(shift_reg))
      else $error("clear disturbed shift register");

   // Shift register moves by one bit per qualified edge
   // Edges are judged on synchronised levels, data shares that delay
   a_shift_on_edge: assert property (@(posedge clk) disable iff (rst)
      do_shift |=> shift_reg == {$past(shift_reg[SDIR_WIDTH-2:0]), $past(sdat)})
      else $error("shift missed a valid edge");
   a_rise_a_shift: assert property (@(posedge clk) disable iff (rst)
      ($rose(sra) ##0 s_idle_but_a) |-> do_shift)
      else $error("rising strobe a did not shift");
   a_rise_b_shift: assert property (@(posedge clk) disable iff (rst)
      ($rose(srb) ##0 s_idle_but_b) |-> do_shift)
      else $error("rising strobe b did not shift");
   a_rise_c_shift: assert property (@(posedge clk) disable iff (rst)
      ($rose(src) ##0 s_idle_but_c) |-> do_shift)
      else $error("rising strobe c did not shift");
   a_fall_edge_shift: assert property (@(posedge clk) disable iff (rst)
      ($fell(sfl) ##0 s_idle_but_fall) |-> do_shift)
      else $error("falling strobe did not shift");

   // A strobe edge with a neighbour busy must be ignored
   // Only one edge can qualify per cycle, so bits never double up
   a_gate_blocks: assert property (@(posedge clk) disable iff (rst)
      ($rose(sra) && (srb || src || !sfl)) |-> !edge_a)
      else $error("gated strobe a shifted");
   a_gate_b: assert property (@(posedge clk) disable iff (rst)
      ($rose(srb) && (sra || src || !sfl)) |-> !edge_b)
      else $error("gated strobe b shifted");
   a_gate_c: assert property (@(posedge clk) disable iff (rst)
      ($rose(src) && (sra || srb || !sfl)) |-> !edge_c)
      else $error("gated strobe c shifted");
   a_gate_fall: assert property (@(posedge clk) disable iff (rst)
      ($fell(sfl) && (sra || srb || src)) |-> !edge_f)
      else $error("gated fall strobe shifted");
   a_one_edge: assert property (@(posedge clk) disable iff (rst)
      $onehot0({edge_a, edge_b, edge_c, edge_f}))
      else $error("more than one strobe edge qualified");
   a_busy_no_shift: assert property (@(posedge clk) disable iff (rst)
      ($countones({sra, srb, src, ~sfl}) > 1) |-> !do_shift)
      else $error("shift with two strobes active");
   a_shift_holds: assert property (@(posedge clk) disable iff (rst)
      !do_shift |=> shift_reg == $past(shift_reg))
      else $error("shift changed without edge");

   // Hold register follows loads; shift register is left alone
   a_load_copies: assert property (@(posedge clk) disable iff (rst)
      s_load_window |-> dac_hold_reg == $past(shift_reg))
      else $error("load did not copy");
   a_comp_follows: assert property (@(posedge clk) disable iff (rst)
      s_load_window |-> current_out_comp == ~$past(shift_reg))
      else $error("complement bus did not follow load");
   a_load_keep_shift: assert property (@(posedge clk) disable iff (rst)
      (do_load && !do_shift) |=> $stable(shift_reg))
      else $error("load disturbed shift register");
   a_hold_keeps: assert property (@(posedge clk) disable iff (rst)
      s_hold_window |-> $stable(dac_hold_reg))
      else $error("hold changed while load high");
   a_steer_comp: assert property (@(posedge clk) disable iff (rst)
      (current_out_main ^ current_out_comp) == 12'hfff)
      else $error("steering outputs not complementary");
endmodule

//--- src/sdir_pkg.sv
// Purpose: Shared constants for the serial converter input registers
// Assumes: One 40 MHz system clock; all pins are asynchronous to it
// Notes:   Widths and codes are fixed at the documented values
package sdir_pkg;
   localparam int          SDIR_WIDTH      = 12;              // Converter code width
   localparam int          SDIR_FULL_SCALE = 4096;            // Unipolar full-scale divisor
   localparam logic [11:0] SDIR_CLEAR_CODE = 12'h000;         // Hold value after clear
   localparam logic [11:0] SDIR_SHIFT_RST  = 12'h000;         // Shift value after reset
   localparam int          SDIR_SYNC_DEPTH = 2;               // Flops per pin synchroniser
   localparam real         SDIR_CLK_NS     = 25.0;            // System clock period, ns
   localparam real         SDIR_CLR_MIN_NS = 200.0;           // Least clear pulse width, ns
   // Least clear width in cycles, rounded up, at least one
   localparam int          SDIR_CLR_CYC    = (SDIR_CLR_MIN_NS / SDIR_CLK_NS) < 1.0 ? 1 :
                                             int'($ceil(SDIR_CLR_MIN_NS / SDIR_CLK_NS));
endpackage

//--- src/sdir_sync.sv
// Purpose: Two-flop synchroniser for a group of asynchronous pins
// Assumes: Inputs are quasi-static against clk
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
module sdir_sync
   import sdir_pkg::*;
#(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Pin side
   input  wire logic [W-1:0] pin_in,
   input  wire logic [W-1:0] rst_value,
   // Synchronised side
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_reg;   // First stage, metastability catcher

   // Two stages, both reset low; the first is read only by the second
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= pin_in;
         sync_out <= meta_reg;
      end
   end
   // rst_value unused by flops: asynchronous reset takes constants only
   logic unused_ok;
   assign unused_ok = ^rst_value;
endmodule

//--- test/sdir_host.sv
// Purpose: Host model driving serial data and the four strobes
// Assumes: One strobe period is eight system clocks, 200 ns
// Notes:   Strobes stand still between frames; data flips when released
`timescale 1ns/1ps
module sdir_host (
   // System clock used as time base
   input  wire logic clk,
   // Strobe and data pins
   output logic      strobe_rise_a,
   output logic      strobe_rise_b,
   output logic      strobe_rise_c,
   output logic      strobe_fall,
   output logic      serial_in
);
   localparam logic [3:0] IDLE = 4'b0100; // Order c, fall, b, a; idle levels
   logic [3:0] stb_reg = IDLE;             // Present strobe levels
   initial serial_in = 1'b0;
   assign {strobe_rise_c, strobe_fall, strobe_rise_b, strobe_rise_a} = stb_reg;
   // Send n bits on strobe sel; jam parks the next strobe non-idle
   task automatic shift_bits(input logic [11:0] w, input int n, input int sel, input logic jam);
      if (jam) begin
         // Neighbour leaves idle: its own edge shifts a one, then all is blocked
         @(posedge clk) stb_reg[(sel + 1) % 4] <= ~IDLE[(sel + 1) % 4];
         serial_in <= 1'b1;
         repeat (4) @(posedge clk);
      end
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge clk) serial_in <= w[i];          // MSB first
         repeat (3) @(posedge clk);
         stb_reg[sel] <= ~IDLE[sel];                 // Active edge, data long settled
         repeat (4) @(posedge clk);
         stb_reg[sel] <= IDLE[sel];                  // Back to idle, data held past edge
      end
      @(posedge clk) stb_reg <= IDLE;               // Frame over, all idle
      serial_in <= ~serial_in;                       // Released line shows no stale bit
   endtask
endmodule

//--- test/tb_top.sv
// Purpose: Self-checking bench for the converter input registers
// Assumes: Host model drives strobes; bench drives loads, clear, reset
// Notes:   Waits are fixed counts taken from the stated latencies
`timescale 1ns/1ps
module tb_top;
   import sdir_pkg::*;
   logic                  clk, rst, load_enable_a, load_enable_b, clear_n; // Bench-driven pins
   wire logic             strobe_rise_a, strobe_rise_b, strobe_rise_c, strobe_fall, serial_in;
   logic [SDIR_WIDTH-1:0] current_out_main, current_out_comp, shift_value, hold_value;
   logic [SDIR_WIDTH-1:0] w, exp_shift, exp_hold;  // Stimulus word and expectations
   int                    fail_count = 0;
   int                    n_tests = 0;
   int                    seed = 32'h8597_a58a;
   sdir_host u_sdir_host (.clk(clk), .strobe_rise_a(strobe_rise_a), .strobe_rise_b(strobe_rise_b),
      .strobe_rise_c(strobe_rise_c), .strobe_fall(strobe_fall), .serial_in(serial_in));
   sdir_top u_sdir_top (.clk(clk), .rst(rst), .strobe_rise_a(strobe_rise_a), .strobe_rise_b(strobe_rise_b),
      .strobe_rise_c(strobe_rise_c), .strobe_fall(strobe_fall), .serial_in(serial_in),
      .load_enable_a(load_enable_a), .load_enable_b(load_enable_b), .clear_n(clear_n),
      .current_out_main(current_out_main), .current_out_comp(current_out_comp),
      .shift_value(shift_value), .hold_value(hold_value));
   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Shift model: n bits of w enter MSB first
   function automatic logic [11:0] push(input logic [11:0] old, input logic [11:0] w, input int n);
      push = old;
      for (int i = n - 1; i >= 0; i--) push = {push[10:0], w[i]};
   endfunction
   task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Loads to given levels long enough for hold to follow, then both high
   task automatic load(input logic a, input logic b);
      @(posedge clk) load_enable_a <= a;
      load_enable_b <= b;
      cyc(8);
      {load_enable_a, load_enable_b} <= 2'b11;
      cyc(2);
   endtask
   task automatic close_out();
      $display("Counts: %0d checks, %0d mismatches", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Watchdog against a hang
   initial begin
      cyc(20000);
      fail_count++;
      close_out();
   end
   initial begin
      rst = 1'b1;
      load_enable_a = 1'b1;
      load_enable_b = 1'b1;
      clear_n = 1'b0;                                    // Clear at start
      cyc(5);
      rst <= 1'b0;
      cyc(8);
      check("hold at start", hold_value, SDIR_CLEAR_CODE);
      check("comp at start", current_out_comp, ~SDIR_CLEAR_CODE);
      clear_n <= 1'b1;
      exp_shift = SDIR_SHIFT_RST;
      for (int s = 0; s < 4; s++) begin
         w = (s == 3) ? 12'hfff : 12'($random(seed));  // Full-scale code as a corner
         u_sdir_host.shift_bits(w, 12, s, 1'b0);
         cyc(4);
         exp_shift = push(exp_shift, w, 12);
         check("shift", shift_value, exp_shift);
         load(1'b0, 1'b0);                             // Full word first
         exp_hold = exp_shift;
         check("hold", hold_value, exp_hold);
         check("main", current_out_main, exp_hold);
         check("comp", current_out_comp, ~exp_hold);
         check("shift kept", shift_value, exp_shift);
         u_sdir_host.shift_bits(~w, 4, s, 1'b0);       // Partial word, one load high
         exp_shift = push(exp_shift, ~w, 4);
         load(s[0], ~s[0]);
         check("hold kept", hold_value, exp_hold);
         u_sdir_host.shift_bits(w, 3, s, 1'b1);        // Neighbour busy: edges refused
         cyc(4);
         exp_shift = push(exp_shift, 12'h001, 1);
         check("shift blocked", shift_value, exp_shift);
         $display("Strobe %0d test done", s);
      end
      // Clear beats loads held low
      @(posedge clk) {load_enable_a, load_enable_b} <= 2'b00;
      cyc(6);
      clear_n <= 1'b0;
      #1 check("cleared", hold_value, SDIR_CLEAR_CODE);
      cyc(8);
      check("clear held", hold_value, SDIR_CLEAR_CODE);
      check("shift on clear", shift_value, exp_shift);
      $display("Clear test done");
      close_out();
   end
endmodule
